// ---- phy_port_pkg.sv ----
// shared constants and carrier types for the phy port register block
package phy_port_pkg;

  // register indices; the byte address is four times the index
  localparam logic [7:0] IDX_BASIC_CTRL = 8'hE4;
  localparam logic [7:0] IDX_ADVERTISE = 8'hEC;
  localparam logic [7:0] IDX_PARTNER = 8'hEE;
  localparam logic [7:0] IDX_SPECIAL = 8'hF4;
  localparam logic [7:0] IDX_PORT_CTRL = 8'hF6;
  localparam logic [7:0] IDX_PORT_STATUS = 8'hF8;

  // port control field positions
  localparam int PC_LED_OFF = 15;
  localparam int PC_TX_DIS = 14;
  localparam int PC_AN_RESTART = 13;
  localparam int PC_MDIX_DIS = 10;
  localparam int PC_MDIX_FORCE = 9;
  localparam int PC_AN_EN = 7;
  localparam int PC_SPEED = 6;
  localparam int PC_DUPLEX = 5;
  localparam int PC_ADV_LSB = 0;

  // basic control field positions, same storage as port control
  localparam int BC_LED_OFF = 0;
  localparam int BC_TX_DIS = 1;
  localparam int BC_MDIX_DIS = 3;
  localparam int BC_MDIX_FORCE = 4;
  localparam int BC_DUPLEX = 8;
  localparam int BC_AN_RESTART = 9;
  localparam int BC_AN_EN = 12;
  localparam int BC_SPEED = 13;

  // ability layout shared by advertisement and partner registers
  localparam int AB_PAUSE = 10;
  localparam int AB_LSB = 5;
  localparam logic [4:0] AB_SELECTOR = 5'h01;

  // special control / cable test field positions
  localparam int SC_RESULT_LSB = 13;
  localparam int SC_START = 12;
  localparam int SC_FORCE_LINK = 11;
  localparam int SC_LOOPBACK = 9;
  localparam int SC_COUNT_LSB = 0;

  // port status field positions
  localparam int ST_SPEED = 10;
  localparam int ST_DUPLEX = 9;
  localparam int ST_MDI = 7;
  localparam int ST_AN_DONE = 6;
  localparam int ST_LINK = 5;
  localparam int ST_PARTNER_LSB = 0;

  // cable test result codes
  localparam logic [1:0] CABLE_NORMAL = 2'h0;
  localparam logic [1:0] CABLE_OPEN = 2'h1;
  localparam logic [1:0] CABLE_SHORT = 2'h2;
  localparam logic [1:0] CABLE_FAIL = 2'h3;

  typedef struct packed {
    logic pause;
    logic fd100;
    logic hd100;
    logic fd10;
    logic hd10;
  } ability_type;

  typedef struct packed {
    logic led_off;
    logic tx_dis;
    logic an_restart;
    logic mdix_dis;
    logic mdix_force;
    logic an_en;
    logic speed100;
    logic full_dup;
    ability_type adv;
  } port_ctrl_type;

  // an_en, speed100, full_dup and all five advertised abilities set
  localparam port_ctrl_type PORT_CTRL_RST = 13'h00FF;

  typedef struct packed {
    ability_type partner;
    logic link_good;
    logic an_done;
    logic speed100;
    logic full_dup;
    logic mdi;
  } phy_status_type;

  typedef struct packed {
    logic tx_dis;
    logic an_en;
    logic mdix_auto;
    logic mdix_force;
    logic speed100;
    logic full_dup;
    ability_type adv;
    logic force_link;
    logic loopback;
  } phy_ctrl_type;

  typedef enum logic {CABLE_IDLE, CABLE_RUN} cable_state_type;

endpackage

// ---- phy_port_ctrl_status_regs.sv ----
// avalon-mm register bank for one phy port: partner, cable test, control
//
// Contract
// (RULE1) partner ability bit 10 is read-only partner pause, equal to status bit 4
// (RULE2) partner bits 8..5 mirror status bits 3..0, partner speed/duplex
// (RULE3) partner bits 15..13 always read zero
// (RULE4) cable result: 00 normal, 01 open, 10 short, 11 test failed
// (RULE5) writing one to bit 12 starts cable test; clears itself when done
// (RULE6) bits 8..0 hold cable fault distance, about 0.4 m per count
// (RULE7) special bit 11 forces link pass
// (RULE8) special bit 9 enables remote loopback receive to transmit
// (RULE9) port control bit 15 drives all four led pins high
// (RULE10) port control bit 14 disables the transmitter
// (RULE11) writing one to port control bit 13 restarts auto-negotiation
// (RULE12) port control bit 10 disables automatic crossover
// (RULE13) bit 9 forces mdi-x only while automatic crossover is disabled
// (RULE14) bit 7 enables auto-negotiation; else speed/duplex from bits 6, 5
// (RULE15) bit 6 forces 100 when set, 10 when clear, without negotiation
// (RULE16) bit 5, default one, forces full duplex; half when clear
// (RULE17) bit 4 controls pause advertisement
// (RULE18) bit 3 controls 100 full duplex advertisement
// (RULE19) port control bits share storage with basic control bits
// (RULE20) bits 2..0 advertise 100 half, 10 full, 10 half; alias advert 7..5
// (RULE21) port status bit 4 reports partner pause, same as partner bit 10
// (RULE22) writes to read-only and reserved fields are ignored
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ps
module phy_port_ctrl_status_regs
  import phy_port_pkg::*;
#(
  parameter int ADDR_W = 10,
  parameter int CABLE_TIMEOUT = 1000000
) (
  input wire logic sys_clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic [ADDR_W-1:0] address, // byte address
  input wire logic read, // avalon read
  input wire logic write, // avalon write
  input wire logic [3:0] byteenable, // byte lanes
  input wire logic [31:0] writedata, // write data
  output logic [31:0] readdata, // read data
  output logic waitrequest, // stall, low one cycle per access
  input wire phy_status_type status_in, // live phy status
  input wire logic cable_done, // cable test finished pulse
  input wire logic [1:0] cable_result, // result code with done
  input wire logic [8:0] cable_count, // fault distance with done
  input wire logic [3:0] led_activity, // led levels in normal use
  output logic [3:0] port_led_pin, // led pins
  output phy_ctrl_type ctrl_out, // control toward the phy core
  output logic an_restart, // restart negotiation pulse
  output logic cable_start // start cable test pulse
);

  localparam int TW = $clog2(CABLE_TIMEOUT + 1);
  localparam logic [TW-1:0] TIMER_END = TW'(CABLE_TIMEOUT - 1);

  logic waitrequest_r;
  logic [31:0] readdata_r;
  logic [15:0] rd_word;
  port_ctrl_type ctrl_r, ctrl_nxt;
  phy_ctrl_type ctrl_out_r;
  logic [3:0] led_r;
  logic force_link_r, force_link_nxt;
  logic loopback_r, loopback_nxt;
  cable_state_type cable_r;
  logic [1:0] result_r;
  logic [8:0] count_r;
  logic [TW-1:0] timer_r;
  logic an_restart_r;
  logic cable_start_r;
  logic wr_go, test_go, restart_go;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [7:0] idx);
    return a[ADDR_W-1:2] == (ADDR_W-2)'(idx);
  endfunction

  // byte-lane merge of a write into the current image
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    return {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  function automatic logic [15:0] pc_img(input port_ctrl_type c);
    logic [15:0] v;
    v = 16'h0000;
    v[PC_LED_OFF] = c.led_off;
    v[PC_TX_DIS] = c.tx_dis;
    v[PC_AN_RESTART] = c.an_restart;
    v[PC_MDIX_DIS] = c.mdix_dis;
    v[PC_MDIX_FORCE] = c.mdix_force;
    v[PC_AN_EN] = c.an_en;
    v[PC_SPEED] = c.speed100;
    v[PC_DUPLEX] = c.full_dup;
    v[PC_ADV_LSB +: 5] = c.adv;
    return v;
  endfunction

  function automatic logic [15:0] bc_img(input port_ctrl_type c);
    logic [15:0] v;
    v = 16'h0000;
    v[BC_LED_OFF] = c.led_off;
    v[BC_TX_DIS] = c.tx_dis;
    v[BC_MDIX_DIS] = c.mdix_dis;
    v[BC_MDIX_FORCE] = c.mdix_force;
    v[BC_DUPLEX] = c.full_dup;
    v[BC_AN_RESTART] = c.an_restart;
    v[BC_AN_EN] = c.an_en;
    v[BC_SPEED] = c.speed100;
    return v;
  endfunction

  // pause at bit 10, speed/duplex abilities at 8..5, selector below
  function automatic logic [15:0] ab_img(input ability_type a);
    logic [15:0] v;
    v = 16'h0000;
    v[AB_PAUSE] = a.pause;
    v[AB_LSB +: 4] = a[3:0];
    v[4:0] = AB_SELECTOR;
    return v;
  endfunction

  // a write commits only at the edge where waitrequest is seen low
  assign wr_go = write && !waitrequest_r;
  assign test_go = wr_go && hit(address, IDX_SPECIAL) && byteenable[1]
                   && writedata[SC_START];
  assign restart_go = wr_go && ((hit(address, IDX_PORT_CTRL)
                      && byteenable[1] && writedata[PC_AN_RESTART])
                      || (hit(address, IDX_BASIC_CTRL)
                      && byteenable[1] && writedata[BC_AN_RESTART]));

  // one wait cycle per access, then one ready cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      waitrequest_r <= 1'b1;
    end else if ((read || write) && waitrequest_r) begin
      waitrequest_r <= 1'b0;
    end else begin
      waitrequest_r <= 1'b1;
    end
  end

  // read image; unmapped addresses read zero
  always_comb begin
    rd_word = 16'h0000;
    if (hit(address, IDX_PORT_CTRL)) begin
      rd_word = pc_img(ctrl_r);
    end else if (hit(address, IDX_BASIC_CTRL)) begin
      rd_word = bc_img(ctrl_r); // see (RULE19)
    end else if (hit(address, IDX_ADVERTISE)) begin
      rd_word = ab_img(ctrl_r.adv); // see (RULE20)
    end else if (hit(address, IDX_PARTNER)) begin
      rd_word = ab_img(status_in.partner); // see (RULE1) see (RULE2)
    end else if (hit(address, IDX_SPECIAL)) begin
      rd_word[SC_RESULT_LSB +: 2] = result_r; // see (RULE4)
      rd_word[SC_START] = (cable_r == CABLE_RUN); // see (RULE5)
      rd_word[SC_FORCE_LINK] = force_link_r;
      rd_word[SC_LOOPBACK] = loopback_r;
      rd_word[SC_COUNT_LSB +: 9] = count_r; // see (RULE6)
    end else if (hit(address, IDX_PORT_STATUS)) begin
      rd_word[ST_SPEED] = status_in.speed100;
      rd_word[ST_DUPLEX] = status_in.full_dup;
      rd_word[ST_MDI] = status_in.mdi;
      rd_word[ST_AN_DONE] = status_in.an_done;
      rd_word[ST_LINK] = status_in.link_good;
      rd_word[ST_PARTNER_LSB +: 5] = status_in.partner; // see (RULE21)
    end
  end

  // read data captured as waitrequest drops, held until the next read
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      readdata_r <= 32'h0000_0000;
    end else if (read && waitrequest_r) begin
      readdata_r <= {16'h0000, rd_word}; // see (RULE3) see (RULE22)
    end
  end

  // one storage for port control, basic control and advertisement views
  always_comb begin
    logic [15:0] m;
    m = 16'h0000;
    ctrl_nxt = ctrl_r;
    if (wr_go && hit(address, IDX_PORT_CTRL)) begin
      m = merge(pc_img(ctrl_r), writedata, byteenable);
      ctrl_nxt.led_off = m[PC_LED_OFF]; // see (RULE9)
      ctrl_nxt.tx_dis = m[PC_TX_DIS]; // see (RULE10)
      ctrl_nxt.an_restart = m[PC_AN_RESTART]; // see (RULE11)
      ctrl_nxt.mdix_dis = m[PC_MDIX_DIS]; // see (RULE12)
      ctrl_nxt.mdix_force = m[PC_MDIX_FORCE]; // see (RULE13)
      ctrl_nxt.an_en = m[PC_AN_EN]; // see (RULE14)
      ctrl_nxt.speed100 = m[PC_SPEED]; // see (RULE15)
      ctrl_nxt.full_dup = m[PC_DUPLEX]; // see (RULE16)
      ctrl_nxt.adv = m[PC_ADV_LSB +: 5]; // see (RULE17) see (RULE18)
    end else if (wr_go && hit(address, IDX_BASIC_CTRL)) begin
      m = merge(bc_img(ctrl_r), writedata, byteenable);
      ctrl_nxt.led_off = m[BC_LED_OFF]; // see (RULE19)
      ctrl_nxt.tx_dis = m[BC_TX_DIS];
      ctrl_nxt.mdix_dis = m[BC_MDIX_DIS];
      ctrl_nxt.mdix_force = m[BC_MDIX_FORCE];
      ctrl_nxt.full_dup = m[BC_DUPLEX];
      ctrl_nxt.an_restart = m[BC_AN_RESTART];
      ctrl_nxt.an_en = m[BC_AN_EN];
      ctrl_nxt.speed100 = m[BC_SPEED];
    end else if (wr_go && hit(address, IDX_ADVERTISE)) begin
      // selector and reserved bits are not stored, so writes drop them
      m = merge(ab_img(ctrl_r.adv), writedata, byteenable);
      ctrl_nxt.adv.pause = m[AB_PAUSE]; // see (RULE17)
      ctrl_nxt.adv[3:0] = m[AB_LSB +: 4]; // see (RULE20)
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_r <= PORT_CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // special register control bits; result and count take no writes
  always_comb begin
    logic [15:0] m;
    m = merge({4'h0, force_link_r, 1'b0, loopback_r, 9'h000},
              writedata, byteenable);
    force_link_nxt = force_link_r;
    loopback_nxt = loopback_r;
    if (wr_go && hit(address, IDX_SPECIAL)) begin
      force_link_nxt = m[SC_FORCE_LINK]; // see (RULE7)
      loopback_nxt = m[SC_LOOPBACK]; // see (RULE8)
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      force_link_r <= 1'b0;
      loopback_r <= 1'b0;
    end else begin
      force_link_r <= force_link_nxt;
      loopback_r <= loopback_nxt;
    end
  end

  // cable test sequencer; a fresh start wins over a done in the same cycle
  // a lost done would hang the test, so a timeout reports failure
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      cable_r <= CABLE_IDLE;
      result_r <= CABLE_NORMAL;
      count_r <= 9'h000;
      timer_r <= '0;
      cable_start_r <= 1'b0;
    end else begin
      cable_start_r <= 1'b0;
      case (cable_r)
        CABLE_IDLE: begin
          if (test_go) begin
            cable_r <= CABLE_RUN; // see (RULE5)
            cable_start_r <= 1'b1;
            timer_r <= '0;
          end
        end
        CABLE_RUN: begin
          timer_r <= timer_r + 1'b1;
          if (test_go && cable_done) begin
            cable_start_r <= 1'b1;
            timer_r <= '0;
          end else if (cable_done) begin
            cable_r <= CABLE_IDLE; // see (RULE5)
            result_r <= cable_result; // see (RULE4)
            count_r <= cable_count; // see (RULE6)
          end else if (timer_r == TIMER_END) begin
            cable_r <= CABLE_IDLE;
            result_r <= CABLE_FAIL; // see (RULE4)
            count_r <= 9'h000;
          end
        end
        default: begin
          cable_r <= CABLE_IDLE;
        end
      endcase
    end
  end

  // negotiation restart pulse on any write of one to the restart bit
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      an_restart_r <= 1'b0;
    end else begin
      an_restart_r <= restart_go; // see (RULE11)
    end
  end

  // registered phy controls; force mdi-x is gated by auto disable
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_out_r <= '0;
    end else begin
      ctrl_out_r.tx_dis <= ctrl_r.tx_dis; // see (RULE10)
      ctrl_out_r.an_en <= ctrl_r.an_en; // see (RULE14)
      ctrl_out_r.mdix_auto <= !ctrl_r.mdix_dis; // see (RULE12)
      ctrl_out_r.mdix_force <= ctrl_r.mdix_dis
                               && ctrl_r.mdix_force; // see (RULE13)
      ctrl_out_r.speed100 <= ctrl_r.speed100; // see (RULE15)
      ctrl_out_r.full_dup <= ctrl_r.full_dup; // see (RULE16)
      ctrl_out_r.adv <= ctrl_r.adv; // see (RULE18) see (RULE20)
      ctrl_out_r.force_link <= force_link_r; // see (RULE7)
      ctrl_out_r.loopback <= loopback_r; // see (RULE8)
    end
  end

  // leds off means pins held high
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      led_r <= 4'hF;
    end else begin
      led_r <= ctrl_r.led_off ? 4'hF : led_activity; // see (RULE9)
    end
  end

  assign readdata = readdata_r;
  assign waitrequest = waitrequest_r;
  assign ctrl_out = ctrl_out_r;
  assign port_led_pin = led_r;
  assign an_restart = an_restart_r;
  assign cable_start = cable_start_r;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  logic rd_pa, rd_st, rd_bc;
  assign rd_pa = read && waitrequest_r && hit(address, IDX_PARTNER);
  assign rd_st = read && waitrequest_r && hit(address, IDX_PORT_STATUS);
  assign rd_bc = read && waitrequest_r && hit(address, IDX_BASIC_CTRL);

  sequence test_launch;
    test_go && cable_r == CABLE_IDLE;
  endsequence

  sequence start_pulse;
    cable_start && cable_r == CABLE_RUN ##1 !cable_start;
  endsequence

  pause_mirror_a: assert property (rd_pa |=> // see (RULE1)
    readdata[AB_PAUSE] == $past(status_in.partner.pause))
    else $error("partner pause bit mismatch");
  ability_mirror_a: assert property (rd_pa |=> // see (RULE2)
    readdata[AB_LSB +: 4] == $past(status_in.partner[3:0]))
    else $error("partner ability bits mismatch");
  unsup_zero_a: assert property (rd_pa |=> // see (RULE3)
    readdata[31:13] == 19'h00000)
    else $error("unsupported partner bits not zero");
  cable_launch_a: assert property (test_launch |=> // see (RULE5)
    start_pulse)
    else $error("cable test did not start");
  cable_capture_a: assert property ( // see (RULE6)
    cable_r == CABLE_RUN && cable_done && !test_go |=>
    cable_r == CABLE_IDLE && count_r == $past(cable_count))
    else $error("cable result not captured");
  cable_fail_a: assert property ( // see (RULE4)
    cable_r == CABLE_RUN && timer_r == TIMER_END && !cable_done
    |=> result_r == CABLE_FAIL)
    else $error("cable timeout not reported as failure");
  led_off_a: assert property (ctrl_r.led_off |=> // see (RULE9)
    port_led_pin == 4'hF)
    else $error("leds not driven high");
  mdix_gate_a: assert property ( // see (RULE13)
    ctrl_out.mdix_force == $past(ctrl_r.mdix_dis && ctrl_r.mdix_force))
    else $error("mdi-x forced while auto enabled");
  restart_pulse_a: assert property (restart_go |=> // see (RULE11)
    an_restart ##1 !an_restart)
    else $error("restart pulse wrong");
  alias_read_a: assert property (rd_bc |=> // see (RULE19)
    readdata[BC_AN_RESTART] == $past(ctrl_r.an_restart))
    else $error("basic control alias mismatch");
  status_pause_a: assert property (rd_st |=> // see (RULE21)
    readdata[ST_PARTNER_LSB + 4] == $past(status_in.partner.pause))
    else $error("status pause mismatch");

endmodule

// ---- phy_core_model.sv ----
// behavioural cable tester standing beside the phy port register block
`timescale 1ns/1ps
module phy_core_model (
  input wire logic sys_clk, // system clock
  input wire logic rst, // async reset, active high
  input wire logic cable_start, // start pulse from the block
  input wire logic reply_en, // zero makes the tester stay silent
  input wire logic [7:0] reply_delay, // done comes this many cycles plus one after the start is taken
  input wire logic [1:0] reply_result, // result code to report
  input wire logic [8:0] reply_count, // fault distance to report
  output logic cable_done, // one-cycle done pulse
  output logic [1:0] cable_result, // valid with done only
  output logic [8:0] cable_count // valid with done only
);
  logic busy_r;
  logic [7:0] wait_r;

  // answer a start after the set delay; outside the done cycle the
  // result lines toggle so a block that samples late reads garbage
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      wait_r <= 8'h00;
      cable_done <= 1'b0;
      cable_result <= 2'h0;
      cable_count <= 9'h000;
    end else begin
      cable_done <= 1'b0;
      cable_result <= ~cable_result;
      cable_count <= ~cable_count;
      if (cable_start && reply_en) begin
        busy_r <= 1'b1;
        wait_r <= reply_delay;
      end else if (busy_r && wait_r == 8'h00) begin
        busy_r <= 1'b0;
        cable_done <= 1'b1;
        cable_result <= reply_result;
        cable_count <= reply_count;
      end else if (busy_r) begin
        wait_r <= wait_r - 8'h01;
      end
    end
  end
endmodule

// ---- tb.sv ----
// self-checking bench for the phy port register block
`timescale 1ns/1ps
module tb;
  import phy_port_pkg::*;
  logic sys_clk, rst, read, write, waitrequest, cable_done;
  logic an_restart, cable_start, reply_en;
  logic [9:0] address;
  logic [3:0] byteenable, led_activity, port_led_pin;
  logic [31:0] writedata, readdata;
  phy_status_type status_in;
  phy_ctrl_type ctrl_out;
  logic [1:0] cable_result, reply_result;
  logic [8:0] cable_count, reply_count;
  logic [7:0] reply_delay;
  int failures, num_checks;
  int restarts = 0;
  int starts = 0;

  phy_port_ctrl_status_regs #(.ADDR_W(10), .CABLE_TIMEOUT(50)) i_dut (
    .sys_clk(sys_clk), .rst(rst), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .status_in(status_in), .cable_done(cable_done),
    .cable_result(cable_result), .cable_count(cable_count),
    .led_activity(led_activity), .port_led_pin(port_led_pin),
    .ctrl_out(ctrl_out), .an_restart(an_restart),
    .cable_start(cable_start));

  phy_core_model i_model (
    .sys_clk(sys_clk), .rst(rst), .cable_start(cable_start),
    .reply_en(reply_en), .reply_delay(reply_delay),
    .reply_result(reply_result), .reply_count(reply_count),
    .cable_done(cable_done), .cable_result(cable_result),
    .cable_count(cable_count));

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // pulses counted mid-cycle, away from the edge that moves them
  always @(negedge sys_clk) begin
    if (an_restart === 1'b1) restarts++;
    if (cable_start === 1'b1) starts++;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // one avalon access; held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [15:0] wd, output logic [15:0] q);
    int n;
    @(posedge sys_clk);
    address <= {idx, 2'h0};
    read <= ~wr;
    write <= wr;
    writedata <= {16'h0000, wd};
    n = 0;
    // waitrequest and readdata are looked at on the rising edge itself
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) begin
      failures++;
      summarize();
    end
    q = readdata[15:0];
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [15:0] wd);
    logic [15:0] q;
    bus(1'b1, idx, wd, q);
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [15:0] exp);
    logic [15:0] q;
    bus(1'b0, idx, 16'h0000, q);
    check(q, exp);
  endtask

  // control and led outputs follow a committed write one edge later
  task automatic settle;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic t_reset;
    rdchk(IDX_PORT_CTRL, 16'h00FF);
    rdchk(IDX_SPECIAL, 16'h0000);
    check(ctrl_out.mdix_auto, 1'b1);
    check(port_led_pin, led_activity);
    rdchk(8'hF0, 16'h0000);
  endtask

  task automatic t_partner;
    logic [4:0] pat [2] = '{5'h16, 5'h09};
    logic [15:0] e;
    foreach (pat[i]) begin
      status_in <= {pat[i], 5'h15};
      e = {5'h00, pat[i][4], 1'b0, pat[i][3:0], 5'h01};
      rdchk(IDX_PARTNER, e);
      rdchk(IDX_PORT_STATUS, 16'h04A0 | pat[i]);
      wr(IDX_PARTNER, 16'hFFFF);
      rdchk(IDX_PARTNER, e);
    end
  endtask

  task automatic t_ctrl;
    logic [15:0] tbl [4] = '{16'hFFFF, 16'h4A55, 16'h0620, 16'h0000};
    logic [15:0] v;
    int r0;
    foreach (tbl[i]) begin
      v = tbl[i];
      r0 = restarts;
      led_activity <= ~v[3:0];
      wr(IDX_PORT_CTRL, v);
      settle();
      check(restarts - r0, v[13]);
      check(ctrl_out.tx_dis, v[14]);
      check(ctrl_out.mdix_auto, !v[10]);
      check(ctrl_out.mdix_force, v[10] & v[9]);
      check(ctrl_out.an_en, v[7]);
      check({ctrl_out.speed100, ctrl_out.full_dup}, v[6:5]);
      check(ctrl_out.adv, v[4:0]);
      check(port_led_pin, v[15] ? 4'hF : led_activity);
      rdchk(IDX_PORT_CTRL, v & 16'hE6FF);
      rdchk(IDX_BASIC_CTRL, {2'h0, v[6], v[7], 2'h0, v[13], v[5], 3'h0,
            v[9], v[10], 1'b0, v[14], v[15]});
      rdchk(IDX_ADVERTISE, {5'h00, v[4], 1'b0, v[3:0], 5'h01});
    end
    // restart through the basic control view must pulse as well
    v = 16'h0000;
    r0 = restarts;
    wr(IDX_BASIC_CTRL, 16'h0201);
    settle();
    check(restarts - r0, 1);
    rdchk(IDX_PORT_CTRL, 16'hA000);
  endtask

  // codes 00..10 come from the tester, 11 from the block's own timeout
  task automatic t_cable;
    logic [15:0] q;
    logic [1:0] k;
    int n, s0;
    for (int i = 0; i < 4; i++) begin
      k = i[1:0];
      s0 = starts;
      reply_en <= (k != 2'h3);
      reply_result <= k;
      reply_count <= 9'h0A5 + 9'(i);
      reply_delay <= 8'h05;
      wr(IDX_SPECIAL, 16'h1A00);
      bus(1'b0, IDX_SPECIAL, 16'h0000, q);
      check(q[12], 1'b1);
      check(starts - s0, 1);
      check(ctrl_out.force_link, 1'b1);
      check(ctrl_out.loopback, 1'b1);
      n = 0;
      while (q[12] !== 1'b0 && n < 40) begin
        bus(1'b0, IDX_SPECIAL, 16'h0000, q);
        n++;
      end
      check(q, {1'b0, k, 4'h5, (k == 2'h3) ? 9'h000 : 9'h0A5 + 9'(i)});
    end
    wr(IDX_SPECIAL, 16'h0000);
    settle();
    check({ctrl_out.force_link, ctrl_out.loopback}, 2'h0);
  endtask

  initial begin
    rst = 1'b1;
    read = 1'b0;
    write = 1'b0;
    address = 10'h000;
    byteenable = 4'h3;
    writedata = 32'h0000_0000;
    status_in = '0;
    led_activity = 4'h5;
    reply_en = 1'b0;
    reply_delay = 8'h00;
    reply_result = 2'h0;
    reply_count = 9'h000;
    failures = 0;
    num_checks = 0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_partner();
    t_ctrl();
    t_cable();
    summarize();
  end
endmodule
